// ===== pkg/ufg_cfg.svh
`ifndef UFG_CFG_SVH
`define UFG_CFG_SVH
// Register addresses on the internal register port
`define UFG_A_IER 5'h01
`define UFG_A_ISR 5'h02
`define UFG_A_FCR 5'h03
`define UFG_A_MCR 5'h04
`define UFG_A_MSR 5'h06
`define UFG_A_DLD 5'h07
`define UFG_A_DLM 5'h08
`define UFG_A_DLL 5'h09
`define UFG_A_SHR 5'h0a
`define UFG_A_SFR 5'h0b
`define UFG_A_EFR 5'h0c
`define UFG_A_RESUME_CHAR_ONE 5'h0d
`define UFG_A_RESUME_CHAR_TWO 5'h0e
`define UFG_A_STOP_CHAR_ONE 5'h0f
`define UFG_A_STOP_CHAR_TWO 5'h10
`define UFG_A_GINT 5'h11
`define UFG_A_GTRI 5'h12
`define UFG_A_GPOL 5'h13
`define UFG_A_GDIR 5'h14
`define UFG_A_GLVL 5'h15
// Bits that only change while the enhanced-enable bit is set
`define UFG_PROT_IER 8'hf0
`define UFG_PROT_FCR 8'h38
`define UFG_PROT_MCR 8'he0
`define UFG_PROT_ALL 8'hff
// Field positions
`define UFG_EFR_ENH 4
`define UFG_EFR_SPC 5
`define UFG_EFR_ARTS 6
`define UFG_EFR_ACTS 7
`define UFG_SFR_BANK 1
`define UFG_IER_MSR 3
`define UFG_IER_SPC 5
`define UFG_IER_RTS 6
`define UFG_MCR_DTR 0
`define UFG_MCR_RTS 1
`define UFG_ISR_SPC 4
`define UFG_ISR_STOP 5
// Reset values
`define UFG_RST_ZERO 8'h00
`define UFG_RST_DIR 16'hffff
`define UFG_POR_DLM 8'h00
`define UFG_POR_DLL 8'h01
`endif

// ===== pkg/ufg_pkg.sv
package ufg_pkg;
  // Automatic request-to-send state, one-hot
  typedef enum logic [1:0] {
    UFG_RTS_OPEN = 2'b01,
    UFG_RTS_HELD = 2'b10
  } ufg_rts_type;
  // Receive flow-control compare selection
  typedef enum logic [1:0] {
    UFG_FLOW_NONE = 2'b00,
    UFG_FLOW_PAIR2 = 2'b01,
    UFG_FLOW_PAIR1 = 2'b10,
    UFG_FLOW_BOTH = 2'b11
  } ufg_flow_type;
endpackage

// ===== pkg/ufg_if.sv
`timescale 1ns/1ps
// Pin configuration out to the GPIO slice, pin state back
interface ufg_gpio_if;
  logic [15:0] dir;
  logic [15:0] tri_st;
  logic [15:0] pol;
  logic [15:0] en;
  logic [15:0] lvl;
  logic [15:0] pin_sync;
  logic [15:0] pin_irq;
  modport regs (output dir, tri_st, pol, en, lvl, input pin_sync, pin_irq);
  modport pins (input dir, tri_st, pol, en, lvl, output pin_sync, pin_irq);
endinterface

// Character compare settings out, match results back
interface ufg_match_if;
  logic spc_en;
  ufg_pkg::ufg_flow_type flow_sel;
  logic [7:0] stop1;
  logic [7:0] stop2;
  logic [7:0] resume1;
  logic [7:0] resume2;
  logic spc_hit;
  logic stop_hit;
  logic resume_hit;
  logic addr_hit;
  logic drop;
  modport regs (output spc_en, flow_sel, stop1, stop2, resume1, resume2,
    input spc_hit, stop_hit, resume_hit, addr_hit, drop);
  modport cmp (input spc_en, flow_sel, stop1, stop2, resume1, resume2,
    output spc_hit, stop_hit, resume_hit, addr_hit, drop);
endinterface

// ===== rtl/ufg_gpio.sv
`timescale 1ns/1ps
module ufg_gpio
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] gpio_in_i,
  output logic [15:0] gpio_out_o,
  output logic [15:0] gpio_oe_n_o,
  ufg_gpio_if.pins cfg
);
  import ufg_pkg::*;
  logic [15:0] meta;
  logic [15:0] sync;

  // Two stages before anything looks at the pins
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= 16'h0000;
      sync <= 16'h0000;
    end
    else
    begin
      meta <= gpio_in_i;
      sync <= meta;
    end
  end

  assign cfg.pin_sync = sync;

  // Per-pin drive and level-sensitive interrupt
  for (genvar i = 0; i < 16; i++)
  begin : g_pin
    assign gpio_out_o[i] = cfg.lvl[i];
    assign gpio_oe_n_o[i] = cfg.dir[i] | cfg.tri_st[i];
    assign cfg.pin_irq[i] = cfg.dir[i] & cfg.en[i] & (sync[i] == cfg.pol[i]);
  end
endmodule

// ===== rtl/ufg_char_match.sv
`timescale 1ns/1ps
module ufg_char_match
(
  input wire logic [7:0] rx_data_i,
  ufg_match_if.cmp cmp
);
  import ufg_pkg::*;
  logic eq_stop1;
  logic eq_stop2;
  logic eq_res1;
  logic eq_res2;

  // Whole-byte compares, bit 0 against the character's first bit
  assign eq_stop1 = rx_data_i == cmp.stop1;
  assign eq_stop2 = rx_data_i == cmp.stop2;
  assign eq_res1 = rx_data_i == cmp.resume1;
  assign eq_res2 = rx_data_i == cmp.resume2;

  // Special character works against the second stop character
  assign cmp.spc_hit = cmp.spc_en & eq_stop2;
  // Second stop character doubles as the multidrop address
  assign cmp.addr_hit = eq_stop2;

  // Flow-control character recognition per compare selection
  always_comb
  begin
    cmp.stop_hit = 1'b0;
    cmp.resume_hit = 1'b0;
    unique case (cmp.flow_sel)
      UFG_FLOW_NONE:
      begin
        cmp.stop_hit = 1'b0;
      end
      UFG_FLOW_PAIR1:
      begin
        cmp.stop_hit = eq_stop1;
        cmp.resume_hit = eq_res1;
      end
      UFG_FLOW_PAIR2:
      begin
        cmp.stop_hit = eq_stop2;
        cmp.resume_hit = eq_res2;
      end
      UFG_FLOW_BOTH:
      begin
        cmp.stop_hit = eq_stop1 | eq_stop2;
        cmp.resume_hit = eq_res1 | eq_res2;
      end
    endcase
  end

  // Second stop character is swallowed only in second-pair mode
  assign cmp.drop = cmp.spc_en & eq_stop2 & (cmp.flow_sel == UFG_FLOW_PAIR2);
endmodule

// ===== rtl/ufg_top.sv
`timescale 1ns/1ps
`include "ufg_cfg.svh"
// How it works
// - Protected enhanced bits and registers accept writes only while enhanced-enable is set.
// - Clearing enhanced-enable freezes the protected settings against later writes.
// - Reset clears every protected enhanced field to zero.
// - Special detect compares each received byte with stop char two, stores it, flags.
// - First-pair flow compare keeps flow control and special detect both working.
// - Second-pair compare drops stop char two, raises stop and gated special interrupts.
// - Auto RTS interrupts at trigger, releases RTS high at upper hysteresis level.
// - Auto RTS pulls RTS low again below lower hysteresis level.
// - Software must assert RTS first; without auto mode RTS is plain output.
// - Auto CTS halts transmit while CTS is high, resumes when low.
// - Stop char two is the address match value in multidrop mode.
// - An input pin raises GPIO interrupt only with its enable bit set.
// - Bank bit picks pins 7..0 or 15..8 for the GPIO registers.
// - Output pin floats when its three-state bit is set, else drives level.
// - Polarity bit zero interrupts on low level, one on high level.
// - Direction bit zero makes output, one input; all pins start as inputs.
// - Divisor latches load 0x00 and 0x01 at power-up only, not pin reset.
// - After reset modem status shows inverted modem pins high, zero low.
module ufg_top
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic por_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_addr_flag_i,
  input wire logic multidrop_en_i,
  input wire logic [7:0] rx_fifo_level_i,
  input wire logic [7:0] rx_trig_level_i,
  output logic rx_store_o,
  output logic [7:0] rx_store_data_o,
  output logic addr_match_o,
  output logic stop_char_o,
  output logic resume_char_o,
  input wire logic tx_bit_i,
  output logic tx_o,
  output logic tx_halt_o,
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic ri_n_i,
  input wire logic cd_n_i,
  output logic rts_n_o,
  output logic dtr_n_o,
  output logic irq_n_o,
  input wire logic [15:0] gpio_in_i,
  output logic [15:0] gpio_out_o,
  output logic [15:0] gpio_oe_n_o,
  output logic [15:0] divisor_o,
  output logic [7:0] fractional_divisor_o,
  output logic [7:0] flow_cfg_o
);
  import ufg_pkg::*;

  logic [7:0] enhanced_feature_ctrl;
  logic [7:0] irq_enable_reg;
  logic [7:0] fifo_ctrl_reg;
  logic [7:0] modem_ctrl_reg;
  logic [7:0] fractional_divisor;
  logic [7:0] hysteresis_reg;
  logic [7:0] special_feature_reg;
  logic [7:0] divisor_high;
  logic [7:0] divisor_low;
  logic [7:0] stop_char_one;
  logic [7:0] stop_char_two;
  logic [7:0] resume_char_one;
  logic [7:0] resume_char_two;
  logic [15:0] pin_irq_enable;
  logic [15:0] pin_tristate_ctrl;
  logic [15:0] pin_irq_polarity;
  logic [15:0] pin_direction;
  logic [15:0] pin_level_reg;
  logic [1:0] irq_flags;
  logic [3:0] modem_meta;
  logic [3:0] modem_sync;
  logic [3:0] modem_prev;
  logic [3:0] modem_delta;
  logic [2:0] modem_primed;
  ufg_rts_type rts_state;
  ufg_rts_type next_rts_state;
  logic [7:0] next_rdata;
  logic [3:0] bank_base;
  logic enh_open;
  logic sys_rst_n;
  logic [8:0] rts_upper;
  logic [8:0] rts_lower;
  logic trig_reached;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  logic msr_read;
  logic [15:0] pin_view;

  ufg_gpio_if gpio_bus ();
  ufg_match_if match_bus ();

  // Power-up reset acts on everything, the reset pin on all but the divisor
  assign sys_rst_n = rst_n_i & por_n_i;
  assign enh_open = enhanced_feature_ctrl[`UFG_EFR_ENH];
  assign bank_base = {special_feature_reg[`UFG_SFR_BANK], 3'b000};

  // Writes to protected bits fall through to the old value when locked
  function automatic logic [7:0] guard(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] prot, input logic open_v);
    guard = open_v ? new_v : ((old_v & prot) | (new_v & ~prot));
  endfunction

  // Enhanced-feature and flow-control character registers
  always_ff @(posedge sys_clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      enhanced_feature_ctrl <= `UFG_RST_ZERO;
      stop_char_one <= `UFG_RST_ZERO;
      stop_char_two <= `UFG_RST_ZERO;
      resume_char_one <= `UFG_RST_ZERO;
      resume_char_two <= `UFG_RST_ZERO;
    end
    else if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        `UFG_A_EFR: enhanced_feature_ctrl <= reg_wdata_i;
        `UFG_A_STOP_CHAR_ONE: stop_char_one <= reg_wdata_i;
        `UFG_A_STOP_CHAR_TWO: stop_char_two <= reg_wdata_i;
        `UFG_A_RESUME_CHAR_ONE: resume_char_one <= reg_wdata_i;
        `UFG_A_RESUME_CHAR_TWO: resume_char_two <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Registers with enhanced fields; locked bits keep their value
  always_ff @(posedge sys_clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      irq_enable_reg <= `UFG_RST_ZERO;
      fifo_ctrl_reg <= `UFG_RST_ZERO;
      modem_ctrl_reg <= `UFG_RST_ZERO;
      fractional_divisor <= `UFG_RST_ZERO;
      hysteresis_reg <= `UFG_RST_ZERO;
      special_feature_reg <= `UFG_RST_ZERO;
    end
    else if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        `UFG_A_IER:
          irq_enable_reg <= guard(irq_enable_reg, reg_wdata_i, `UFG_PROT_IER, enh_open);
        `UFG_A_FCR:
          fifo_ctrl_reg <= guard(fifo_ctrl_reg, reg_wdata_i, `UFG_PROT_FCR, enh_open);
        `UFG_A_MCR:
          modem_ctrl_reg <= guard(modem_ctrl_reg, reg_wdata_i, `UFG_PROT_MCR, enh_open);
        `UFG_A_DLD:
          fractional_divisor <= guard(fractional_divisor, reg_wdata_i, `UFG_PROT_ALL,
                                      enh_open);
        `UFG_A_SHR:
          hysteresis_reg <= guard(hysteresis_reg, reg_wdata_i, `UFG_PROT_ALL, enh_open);
        `UFG_A_SFR:
          special_feature_reg <= guard(special_feature_reg, reg_wdata_i, `UFG_PROT_ALL,
                                       enh_open);
        default: ;
      endcase
    end
  end

  // Divisor latches only see the power-up reset, so a pin reset keeps divisor_o but clears the fractional divisor
  always_ff @(posedge sys_clk_i or negedge por_n_i)
  begin
    if (!por_n_i)
    begin
      divisor_high <= `UFG_POR_DLM;
      divisor_low <= `UFG_POR_DLL;
    end
    else if (reg_wr_i && reg_addr_i == `UFG_A_DLM)
    begin
      divisor_high <= reg_wdata_i;
    end
    else if (reg_wr_i && reg_addr_i == `UFG_A_DLL)
    begin
      divisor_low <= reg_wdata_i;
    end
  end

  // GPIO registers, the bank bit chooses which half a write reaches
  always_ff @(posedge sys_clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      pin_irq_enable <= 16'h0000;
      pin_tristate_ctrl <= 16'h0000;
      pin_irq_polarity <= 16'h0000;
      pin_direction <= `UFG_RST_DIR;
      pin_level_reg <= 16'h0000;
    end
    else if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        `UFG_A_GINT: pin_irq_enable[bank_base +: 8] <= reg_wdata_i;
        `UFG_A_GTRI: pin_tristate_ctrl[bank_base +: 8] <= reg_wdata_i;
        `UFG_A_GPOL: pin_irq_polarity[bank_base +: 8] <= reg_wdata_i;
        `UFG_A_GDIR: pin_direction[bank_base +: 8] <= reg_wdata_i;
        `UFG_A_GLVL: pin_level_reg[bank_base +: 8] <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  assign gpio_bus.dir = pin_direction;
  assign gpio_bus.tri_st = pin_tristate_ctrl;
  assign gpio_bus.pol = pin_irq_polarity;
  assign gpio_bus.en = pin_irq_enable;
  assign gpio_bus.lvl = pin_level_reg;

  ufg_gpio u_gpio
  (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(sys_rst_n),
    .gpio_in_i(gpio_in_i),
    .gpio_out_o(gpio_out_o),
    .gpio_oe_n_o(gpio_oe_n_o),
    .cfg(gpio_bus.pins)
  );

  // Level reads show the pin for inputs and the latch for outputs
  assign pin_view = (gpio_bus.pin_sync & pin_direction) | (pin_level_reg & ~pin_direction);

  assign match_bus.spc_en = enhanced_feature_ctrl[`UFG_EFR_SPC];
  assign match_bus.flow_sel = ufg_flow_type'(enhanced_feature_ctrl[1:0]);
  assign match_bus.stop1 = stop_char_one;
  assign match_bus.stop2 = stop_char_two;
  assign match_bus.resume1 = resume_char_one;
  assign match_bus.resume2 = resume_char_two;

  ufg_char_match u_match
  (
    .rx_data_i(rx_data_i),
    .cmp(match_bus.cmp)
  );

  // Receive path: forward or swallow each character, report compares
  always_ff @(posedge sys_clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      rx_store_o <= 1'b0;
      rx_store_data_o <= 8'h00;
      addr_match_o <= 1'b0;
      stop_char_o <= 1'b0;
      resume_char_o <= 1'b0;
    end
    else
    begin
      rx_store_o <= rx_valid_i & ~match_bus.drop;
      if (rx_valid_i)
      begin
        rx_store_data_o <= rx_data_i;
      end
      addr_match_o <= rx_valid_i & multidrop_en_i & rx_addr_flag_i & match_bus.addr_hit;
      stop_char_o <= rx_valid_i & match_bus.stop_hit;
      resume_char_o <= rx_valid_i & match_bus.resume_hit;
    end
  end

  // Sticky status bits 4 and 5; a new hit wins over a clearing write
  assign flag_set[0] = rx_valid_i & match_bus.spc_hit;
  assign flag_set[1] = rx_valid_i & match_bus.stop_hit & match_bus.drop;
  assign flag_clr = (reg_wr_i && reg_addr_i == `UFG_A_ISR && enh_open) ?
                    reg_wdata_i[`UFG_ISR_STOP:`UFG_ISR_SPC] : 2'b00;

  always_ff @(posedge sys_clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      irq_flags <= 2'b00;
    end
    else
    begin
      irq_flags <= (irq_flags & ~flag_clr) | flag_set;
    end
  end

  // Modem inputs come from pins, so they pass two stages first
  always_ff @(posedge sys_clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      modem_meta <= 4'hf;
      modem_sync <= 4'hf;
    end
    else
    begin
      modem_meta <= {cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
      modem_sync <= modem_meta;
    end
  end

  // Change bits wait until sync and prev both hold real pin samples after reset,
  // otherwise the reset value of the sync stages reads as a false change
  assign msr_read = reg_rd_i && reg_addr_i == `UFG_A_MSR;

  always_ff @(posedge sys_clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      modem_prev <= 4'hf;
      modem_primed <= 3'b000;
      modem_delta <= 4'h0;
    end
    else
    begin
      modem_prev <= modem_sync;
      modem_primed <= {modem_primed[1:0], 1'b1};
      modem_delta <= (msr_read ? 4'h0 : modem_delta) |
                     ({4{modem_primed[2]}} & (modem_sync ^ modem_prev));
    end
  end

  // Auto RTS thresholds: trigger plus or minus the hysteresis count
  assign rts_upper = {1'b0, rx_trig_level_i} + {1'b0, hysteresis_reg};
  assign rts_lower = (rx_trig_level_i > hysteresis_reg) ?
                     {1'b0, rx_trig_level_i} - {1'b0, hysteresis_reg} : 9'h000;
  assign trig_reached = {1'b0, rx_fifo_level_i} >= {1'b0, rx_trig_level_i};

  always_comb
  begin
    next_rts_state = rts_state;
    unique case (rts_state)
      UFG_RTS_OPEN:
      begin
        if ({1'b0, rx_fifo_level_i} >= rts_upper)
        begin
          next_rts_state = UFG_RTS_HELD;
        end
      end
      UFG_RTS_HELD:
      begin
        if ({1'b0, rx_fifo_level_i} < rts_lower)
        begin
          next_rts_state = UFG_RTS_OPEN;
        end
      end
      default: next_rts_state = UFG_RTS_OPEN;
    endcase
  end

  // Flow state only runs while auto RTS is on and software asserted RTS
  always_ff @(posedge sys_clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      rts_state <= UFG_RTS_OPEN;
    end
    else if (enhanced_feature_ctrl[`UFG_EFR_ARTS] && modem_ctrl_reg[`UFG_MCR_RTS])
    begin
      rts_state <= next_rts_state;
    end
    else
    begin
      rts_state <= UFG_RTS_OPEN;
    end
  end

  // Modem outputs and the transmit gate are all registered
  always_ff @(posedge sys_clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
      tx_o <= 1'b1;
      tx_halt_o <= 1'b0;
    end
    else
    begin
      rts_n_o <= ~modem_ctrl_reg[`UFG_MCR_RTS] | (rts_state == UFG_RTS_HELD);
      dtr_n_o <= ~modem_ctrl_reg[`UFG_MCR_DTR];
      tx_o <= tx_bit_i;
      tx_halt_o <= enhanced_feature_ctrl[`UFG_EFR_ACTS] & modem_sync[0];
    end
  end

  // Interrupt line is low while any enabled source is pending
  always_ff @(posedge sys_clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      irq_n_o <= 1'b1;
    end
    else
    begin
      irq_n_o <= ~((irq_flags[0] & irq_enable_reg[`UFG_IER_SPC]) |
                   (irq_flags[1] & irq_enable_reg[`UFG_IER_SPC]) |
                   (trig_reached & enhanced_feature_ctrl[`UFG_EFR_ARTS] &
                    irq_enable_reg[`UFG_IER_RTS]) |
                   ((|modem_delta) & irq_enable_reg[`UFG_IER_MSR]) |
                   (|gpio_bus.pin_irq));
    end
  end

  // Read mux; unmapped addresses answer zero
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (reg_addr_i)
      `UFG_A_IER: next_rdata = irq_enable_reg;
      `UFG_A_ISR: next_rdata = {2'b00, irq_flags, 4'h0};
      `UFG_A_FCR: next_rdata = fifo_ctrl_reg;
      `UFG_A_MCR: next_rdata = modem_ctrl_reg;
      `UFG_A_MSR: next_rdata = {~modem_sync, modem_delta};
      `UFG_A_DLD: next_rdata = fractional_divisor;
      `UFG_A_DLM: next_rdata = divisor_high;
      `UFG_A_DLL: next_rdata = divisor_low;
      `UFG_A_SHR: next_rdata = hysteresis_reg;
      `UFG_A_SFR: next_rdata = special_feature_reg;
      `UFG_A_EFR: next_rdata = enhanced_feature_ctrl;
      `UFG_A_RESUME_CHAR_ONE: next_rdata = resume_char_one;
      `UFG_A_RESUME_CHAR_TWO: next_rdata = resume_char_two;
      `UFG_A_STOP_CHAR_ONE: next_rdata = stop_char_one;
      `UFG_A_STOP_CHAR_TWO: next_rdata = stop_char_two;
      `UFG_A_GINT: next_rdata = pin_irq_enable[bank_base +: 8];
      `UFG_A_GTRI: next_rdata = pin_tristate_ctrl[bank_base +: 8];
      `UFG_A_GPOL: next_rdata = pin_irq_polarity[bank_base +: 8];
      `UFG_A_GDIR: next_rdata = pin_direction[bank_base +: 8];
      `UFG_A_GLVL: next_rdata = pin_view[bank_base +: 8];
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data held until the next read strobe
  always_ff @(posedge sys_clk_i or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (reg_rd_i)
    begin
      reg_rdata_o <= next_rdata;
    end
  end

  // Configuration seen by the baud generator and flow engine elsewhere
  assign divisor_o = {divisor_high, divisor_low};
  assign fractional_divisor_o = fractional_divisor;
  assign flow_cfg_o = enhanced_feature_ctrl;
endmodule

// ===== test/ufg_asserts.sv
`timescale 1ns/1ps
module ufg_asserts
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic por_n_i,
  input wire logic reg_wr_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_store_o,
  input wire logic [7:0] rx_store_data_o,
  input wire logic stop_char_o,
  input wire logic cts_n_i,
  input wire logic tx_halt_o,
  input wire logic [7:0] flow_cfg_o,
  input wire logic rts_n_o,
  input wire logic tx_o,
  input wire logic dtr_n_o,
  input wire logic irq_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i || !por_n_i);
  // CTS must stay put through the two sync flops and the halt register
  sequence s_cts_hi;
    (flow_cfg_o[7] && cts_n_i) [*4];
  endsequence
  sequence s_cts_lo;
    (!cts_n_i) [*4];
  endsequence
  sequence s_pair2_rx;
    rx_valid_i && flow_cfg_o[5] && flow_cfg_o[1:0] == 2'b01;
  endsequence
  sequence s_mcr_wr;
    (reg_wr_i && reg_addr_i == 5'h04 && !flow_cfg_o[6]) ##1 (!reg_wr_i && !flow_cfg_o[6]);
  endsequence
  property p_efr_wr;
    reg_wr_i && reg_addr_i == 5'h0c |=> flow_cfg_o == $past(reg_wdata_i);
  endproperty
  property p_rst_out;
    disable iff (!por_n_i) !rst_n_i |-> tx_o && rts_n_o && dtr_n_o && irq_n_o;
  endproperty
  property p_halt;
    s_cts_hi |-> tx_halt_o;
  endproperty
  property p_resume;
    s_cts_lo |-> !tx_halt_o;
  endproperty
  property p_store;
    rx_valid_i && flow_cfg_o[1:0] != 2'b01 |=> rx_store_o && rx_store_data_o == $past(rx_data_i);
  endproperty
  property p_no_store;
    !rx_valid_i |=> !rx_store_o;
  endproperty
  property p_swallow;
    s_pair2_rx |=> stop_char_o != rx_store_o;
  endproperty
  property p_rts_sw;
    s_mcr_wr |=> rts_n_o == !$past(reg_wdata_i[1], 2);
  endproperty
  a_efr_wr: assert property (p_efr_wr) else $error("enhanced control write lost");
  a_rst_out: assert property (p_rst_out) else $error("outputs not high in reset");
  a_halt: assert property (p_halt) else $error("transmit not halted");
  a_resume: assert property (p_resume) else $error("transmit not resumed");
  a_store: assert property (p_store) else $error("character not stored");
  a_no_store: assert property (p_no_store) else $error("store without character");
  a_swallow: assert property (p_swallow) else $error("stop char handling wrong");
  a_rts_sw: assert property (p_rts_sw) else $error("rts not plain output");
endmodule

bind ufg_top ufg_asserts u_ufg_asserts (.sys_clk_i, .rst_n_i, .por_n_i, .reg_wr_i, .reg_addr_i,
  .reg_wdata_i, .rx_valid_i, .rx_data_i, .rx_store_o, .rx_store_data_o, .stop_char_o,
  .cts_n_i, .tx_halt_o, .flow_cfg_o, .rts_n_o, .tx_o, .dtr_n_o, .irq_n_o);

// ===== test/ufg_remote.sv
`timescale 1ns/1ps
module ufg_remote
(
  input wire logic sys_clk_i,
  input wire logic hold_i,
  input wire logic [15:0] pins_i,
  output logic [3:0] modem_n_o,
  output logic [15:0] pins_o
);
  // Far end changes its lines on the clock; unused modem lines idle inactive
  always_ff @(posedge sys_clk_i)
  begin
    modem_n_o <= {3'b111, hold_i};
    pins_o <= pins_i;
  end
endmodule

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, por_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic rx_valid_i = 1'b0, hold = 1'b0, rd_d = 1'b0, tx_bit_i = 1'b1;
  logic [4:0] reg_addr_i = 5'h00;
  logic [7:0] reg_wdata_i = 8'h00, rx_data_i = 8'h00, fifo = 8'h00, trig = 8'h00, lv;
  logic [7:0] reg_rdata_o, rx_store_data_o, exp_q[$];
  logic rx_store_o, stop_char_o, tx_o, tx_halt_o, rts_n_o, irq_n_o;
  logic [15:0] gpio_out_o, gpio_oe_n_o, divisor_o, far_q, gpio_in;
  logic [3:0] modem;
  integer seed = 32'h3836e9dd;
  int err_total = 0, check_count = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  // Pin level: whoever has the pin enabled wins
  assign gpio_in = (gpio_oe_n_o & far_q) | (~gpio_oe_n_o & gpio_out_o);
  ufg_remote u_ufg_remote (.sys_clk_i, .hold_i(hold), .pins_i(16'h0001), .modem_n_o(modem),
    .pins_o(far_q));
  ufg_top u_ufg_top (.sys_clk_i, .rst_n_i, .por_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .rx_valid_i, .rx_data_i, .rx_addr_flag_i(1'b0),
    .multidrop_en_i(1'b0), .rx_fifo_level_i(fifo), .rx_trig_level_i(trig), .rx_store_o,
    .rx_store_data_o, .addr_match_o(), .stop_char_o, .resume_char_o(), .tx_bit_i, .tx_o,
    .tx_halt_o, .cts_n_i(modem[0]), .dsr_n_i(modem[1]), .ri_n_i(modem[2]), .cd_n_i(modem[3]),
    .rts_n_o, .dtr_n_o(), .irq_n_o, .gpio_in_i(gpio_in), .gpio_out_o, .gpio_oe_n_o,
    .divisor_o, .fractional_divisor_o(), .flow_cfg_o());
  task cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task chk(input string what, input logic [15:0] e, input logic [15:0] got);
    check_count++;
    if (got !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, e, got);
    end
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    cyc(1);
    reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
    cyc(1);
    reg_wr_i <= 1'b0;
  endtask
  // Expected read data is queued here and compared by the monitor
  task rd(input logic [4:0] a, input logic [7:0] e);
    cyc(1);
    reg_rd_i <= 1'b1; reg_addr_i <= a; exp_q.push_back(e);
    cyc(1);
    reg_rd_i <= 1'b0;
  endtask
  task rxc(input logic [7:0] d);
    cyc(1);
    rx_valid_i <= 1'b1; rx_data_i <= d;
    cyc(1);
    rx_valid_i <= 1'b0;
    cyc(1);
  endtask
  task test_done;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Read data lands one edge after the read is taken
  always @(posedge sys_clk_i)
  begin
    rd_d <= reg_rd_i;
    if (rd_d)
      chk("rdata", exp_q.pop_front(), {8'h00, reg_rdata_o});
  end
  // Hang guard
  initial
  begin
    cyc(20000);
    err_total++;
    test_done;
  end
  initial
  begin
    cyc(8);
    rst_n_i <= 1'b1; por_n_i <= 1'b1;
    cyc(1);
    chk("divisor", 16'h0001, divisor_o);
    foreach (exp_q[i]) cyc(0);
    for (int a = 12; a < 20; a++) rd(a[4:0], 8'h00);
    rd(5'h14, 8'hff);
    rd(5'h06, 8'h10);
    wr(5'h01, 8'hff);
    rd(5'h01, 8'h0f);
    wr(5'h0c, 8'h10); wr(5'h01, 8'hff); wr(5'h0a, 8'h02);
    rd(5'h01, 8'hff);
    wr(5'h0c, 8'h00); wr(5'h01, 8'h00); wr(5'h0a, 8'h00);
    rd(5'h01, 8'hf0);
    rd(5'h0a, 8'h02);
    lv = $random(seed);
    wr(5'h14, 8'h00); wr(5'h12, 8'h0f); wr(5'h15, lv);
    cyc(1);
    chk("oe", 16'hff0f, gpio_oe_n_o);
    chk("out", {8'h00, lv}, gpio_out_o);
    wr(5'h14, 8'hff); wr(5'h13, 8'h01); wr(5'h11, 8'h01);
    cyc(4);
    chk("irq", 16'h0000, irq_n_o);
    wr(5'h11, 8'h00);
    cyc(4);
    chk("irq", 16'h0001, irq_n_o);
    wr(5'h11, 8'h01); wr(5'h13, 8'h00);
    cyc(4);
    chk("irq", 16'h0001, irq_n_o);
    wr(5'h0c, 8'h10); wr(5'h0b, 8'h02); wr(5'h14, 8'h00);
    cyc(1);
    chk("oe", 16'h00ff, gpio_oe_n_o);
    wr(5'h09, 8'h5a);
    rst_n_i <= 1'b0;
    cyc(2);
    rst_n_i <= 1'b1;
    cyc(1);
    chk("divisor", 16'h005a, divisor_o);
    rd(5'h01, 8'h00);
    rd(5'h0b, 8'h00);
    lv = $random(seed) | 8'h01;
    wr(5'h0c, 8'h10); wr(5'h01, 8'h20); wr(5'h10, lv); wr(5'h0c, 8'h21);
    rxc(lv);
    chk("store", 16'h0000, rx_store_o);
    chk("stop", 16'h0001, stop_char_o);
    cyc(1);
    chk("irq", 16'h0000, irq_n_o);
    wr(5'h0c, 8'h32); wr(5'h02, 8'h30);
    rxc(lv);
    chk("store", 16'h0001, rx_store_o);
    chk("sdata", {8'h00, lv}, rx_store_data_o);
    rd(5'h02, 8'h10);
    wr(5'h02, 8'h30); trig <= 8'h08;
    wr(5'h04, 8'h02); wr(5'h01, 8'h40); wr(5'h0c, 8'h50); wr(5'h0a, 8'h02);
    cyc(1);
    chk("rts", 16'h0000, rts_n_o);
    fifo <= 8'h08;
    cyc(3);
    chk("irq", 16'h0000, irq_n_o);
    fifo <= 8'h0b;
    cyc(3);
    chk("rts", 16'h0001, rts_n_o);
    fifo <= 8'h07;
    cyc(3);
    chk("rts", 16'h0001, rts_n_o);
    fifo <= 8'h05;
    cyc(3);
    chk("rts", 16'h0000, rts_n_o);
    wr(5'h0c, 8'h80); hold <= 1'b1;
    cyc(5);
    chk("halt", 16'h0001, tx_halt_o);
    hold <= 1'b0;
    cyc(5);
    chk("halt", 16'h0000, tx_halt_o);
    cyc(2);
    test_done;
  end
endmodule
